// ==== design/splu_core.sv ====
// stack pop and register pair load sequencer of the core load unit
//
// Contract
// - pop address is base plus count times eight
// - new stack pointer goes to fault scratch
// - count above one loads upper pair
// - pair half equal to base is skipped
// - link register loaded from address plus four
// - base register written with address last
// - bad pop forms raise illegal instruction
// - unaligned base raises alignment fault when the pop form is valid
// - synchronous fault leaves target and link untouched
// - fault address recorded in fault scratch
// - only completed reads update registers after fault
// - async events wait until all writes done; held ones are dropped at the update form base write
// - stack pointer never loaded from memory
// - back pointer word is never read
// - displacement pair load from base-or-zero plus disp
// - invalid pair target raises illegal instruction
// - update form writes address back to base
// - update form illegal for zero or overlapping base
// - indexed pair load sums index and base-or-zero
`timescale 1ns/1ps
module splu_core (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // instruction issue
  input  wire logic        issue_valid,
  output logic             issue_ready,
  input  wire logic [31:0] instr,
  input  wire logic [31:0] base_val,
  input  wire logic [31:0] index_val,
  input  wire logic        prior_store_fault,
  // memory load port
  output logic             mem_req,
  output logic [31:0]      mem_addr,
  output logic [3:0]       mem_size,
  input  wire logic        mem_ack,
  input  wire logic        mem_err,
  input  wire logic [63:0] mem_rdata,
  // register writeback
  output logic             gpr_we,
  output logic [4:0]       gpr_waddr,
  output logic [31:0]      gpr_wdata,
  output logic             gpr_we2,
  output logic [4:0]       gpr_waddr2,
  output logic [31:0]      gpr_wdata2,
  output logic             link_reg_we,
  output logic [31:0]      link_reg_wdata,
  output logic [31:0]      fault_address_scratch_reg,
  // completion and exceptions
  output logic             done,
  output logic             illegal_instr,
  output logic             align_fault,
  output logic             data_fault,
  output logic             busy,
  input  wire logic        async_event,
  output logic             async_take
);
  // decoded fields
  logic [4:0]  target_reg_field;
  logic [4:0]  base_reg_field;
  logic [12:0] doubleword_count_field;
  logic [31:0] disp_ext;
  logic [31:0] cnt_ext;
  logic        is_pop;
  logic        is_pair_d;
  logic        is_pair_u;
  logic        is_pair_x;
  logic        pop_bad;
  logic        pair_bad;
  logic        take;
  // sequencer registers
  splu_pkg::splu_state_e state_q;
  logic [31:0] ea_q;
  logic [4:0]  base_q;
  logic [4:0]  tgt_q;
  logic        upd_q;
  logic        do_lower_q;
  logic        pend_q;
  logic [63:0] rd_hold;
  logic        rd_cap;
  logic        upd_wb_q;

  // valid pair target: an even register number names a pair
  function automatic logic pair_ok(input logic [4:0] r);
    pair_ok = (r[0] == 1'b0);
  endfunction : pair_ok

  // skip a half whose register is the stack pointer base
  function automatic logic keep_half(input logic [4:0] r, input logic [4:0] b);
    keep_half = (r != b);
  endfunction : keep_half

  // field extraction and opcode decode
  always_comb begin
    target_reg_field       = instr[splu_pkg::TGT_MSB:splu_pkg::TGT_LSB];
    base_reg_field         = instr[splu_pkg::BASE_MSB:splu_pkg::BASE_LSB];
    doubleword_count_field = instr[splu_pkg::CNT_MSB:splu_pkg::CNT_LSB];
    disp_ext  = {{16{instr[splu_pkg::DISP_MSB]}}, instr[splu_pkg::DISP_MSB:splu_pkg::DISP_LSB]};
    cnt_ext   = {{16{doubleword_count_field[12]}}, doubleword_count_field,
                 splu_pkg::ZERO3};
    is_pop    = (instr[splu_pkg::OPC_MSB:splu_pkg::OPC_LSB] == splu_pkg::OPC_POP) &&
                (instr[splu_pkg::SUB_MSB:splu_pkg::SUB_LSB] == splu_pkg::SUB_POP);
    is_pair_d = instr[splu_pkg::OPC_MSB:splu_pkg::OPC_LSB] == splu_pkg::OPC_PAIR;
    is_pair_u = instr[splu_pkg::OPC_MSB:splu_pkg::OPC_LSB] == splu_pkg::OPC_PAIR_U;
    is_pair_x = (instr[splu_pkg::OPC_MSB:splu_pkg::OPC_LSB] == splu_pkg::OPC_XFORM) &&
                (instr[splu_pkg::XO_MSB:splu_pkg::XO_LSB] == splu_pkg::XO_PAIR_X);
    // invalid pop forms
    pop_bad   = (base_reg_field == splu_pkg::REG_ZERO) ||
                (target_reg_field != base_reg_field) ||
                doubleword_count_field[12] ||
                (doubleword_count_field[11:0] == '0);
    // invalid pair forms
    pair_bad  = !pair_ok(target_reg_field) ||
                (is_pair_u && ((base_reg_field == splu_pkg::REG_ZERO) ||
                               (base_reg_field == target_reg_field) ||
                               (base_reg_field == 5'(target_reg_field + 5'h01))));
  end

  // a request is taken only while idle
  assign issue_ready = (state_q == splu_pkg::ST_IDLE);
  assign busy        = !issue_ready;
  assign take        = issue_valid && issue_ready && (is_pop || is_pair_d || is_pair_u ||
                                                     is_pair_x);
  assign rd_cap      = mem_req && mem_ack && !mem_err;

  // read data holding register
  splu_rdata_reg #(.WIDTH(64)) u_rdata (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .load     (rd_cap),
    .wdata    (mem_rdata),
    .rdata    (rd_hold)
  );

  // sequencer: one read per state, base write only at the end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q    <= splu_pkg::ST_IDLE;
      ea_q       <= '0;
      base_q     <= '0;
      tgt_q      <= '0;
      upd_q      <= 1'b0;
      do_lower_q <= 1'b0;
    end else begin
      case (state_q)
        splu_pkg::ST_IDLE: begin
          if (take && is_pop && !pop_bad && !prior_store_fault &&
              ((base_val[2:0] & splu_pkg::ALIGN_MASK) == splu_pkg::ZERO3)) begin
            ea_q       <= base_val + cnt_ext;
            base_q     <= base_reg_field;
            tgt_q      <= target_reg_field;
            do_lower_q <= doubleword_count_field > splu_pkg::CNT_TWO;
            // count of one reads only the link word
            state_q    <= (doubleword_count_field > splu_pkg::CNT_ONE) ?
                          splu_pkg::ST_UPPER : splu_pkg::ST_LINK;
          end else if (take && !is_pop && !pair_bad && !prior_store_fault) begin
            // pair load address forms
            if (is_pair_x) begin
              ea_q <= ((base_reg_field == splu_pkg::REG_ZERO) ? 32'h0 : base_val) +
                      index_val;
            end else if (is_pair_u) begin
              ea_q <= base_val + disp_ext;
            end else begin
              ea_q <= ((base_reg_field == splu_pkg::REG_ZERO) ? 32'h0 : base_val) +
                      disp_ext;
            end
            base_q  <= base_reg_field;
            tgt_q   <= target_reg_field;
            upd_q   <= is_pair_u;
            state_q <= splu_pkg::ST_PAIR;
          end
        end
        // each read state waits for its ack, faults end the pop
        splu_pkg::ST_UPPER: begin
          if (mem_ack) begin
            state_q <= mem_err ? splu_pkg::ST_IDLE :
                       (do_lower_q ? splu_pkg::ST_LOWER : splu_pkg::ST_LINK);
          end
        end
        splu_pkg::ST_LOWER: begin
          if (mem_ack) begin
            state_q <= mem_err ? splu_pkg::ST_IDLE : splu_pkg::ST_LINK;
          end
        end
        splu_pkg::ST_LINK: begin
          if (mem_ack) begin
            state_q <= mem_err ? splu_pkg::ST_IDLE : splu_pkg::ST_BASE;
          end
        end
        splu_pkg::ST_BASE: begin
          state_q <= splu_pkg::ST_IDLE;
        end
        splu_pkg::ST_PAIR: begin
          if (mem_ack) begin
            state_q <= splu_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= splu_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // memory request: the back pointer word at the address is never fetched
  always_comb begin
    mem_req  = 1'b0;
    mem_addr = ea_q;
    mem_size = splu_pkg::ACC_DWORD;
    case (state_q)
      splu_pkg::ST_UPPER: begin
        mem_req  = 1'b1;
        mem_addr = ea_q + splu_pkg::OFS_UPPER;
      end
      splu_pkg::ST_LOWER: begin
        mem_req  = 1'b1;
        mem_addr = ea_q + splu_pkg::OFS_LOWER;
      end
      splu_pkg::ST_LINK: begin
        mem_req  = 1'b1;
        mem_addr = ea_q + splu_pkg::OFS_LINK;
        mem_size = splu_pkg::ACC_WORD;
      end
      splu_pkg::ST_PAIR: begin
        mem_req  = 1'b1;
      end
      default: begin
        mem_req  = 1'b0;
      end
    endcase
  end

  // register writeback, issued straight from a good read
  always_comb begin
    gpr_we         = 1'b0;
    gpr_waddr      = splu_pkg::REG_ZERO;
    gpr_wdata      = mem_rdata[63:32];
    gpr_we2        = 1'b0;
    gpr_waddr2     = splu_pkg::REG_ZERO;
    gpr_wdata2     = mem_rdata[31:0];
    link_reg_we    = 1'b0;
    link_reg_wdata = mem_rdata[31:0];
    case (state_q)
      splu_pkg::ST_UPPER: begin
        gpr_we     = rd_cap && keep_half(splu_pkg::REG_UP_HI, base_q);
        gpr_waddr  = splu_pkg::REG_UP_HI;
        gpr_we2    = rd_cap && keep_half(splu_pkg::REG_UP_LO, base_q);
        gpr_waddr2 = splu_pkg::REG_UP_LO;
      end
      splu_pkg::ST_LOWER: begin
        gpr_we     = rd_cap && keep_half(splu_pkg::REG_LO_HI, base_q);
        gpr_waddr  = splu_pkg::REG_LO_HI;
        gpr_we2    = rd_cap && keep_half(splu_pkg::REG_LO_LO, base_q);
        gpr_waddr2 = splu_pkg::REG_LO_LO;
      end
      splu_pkg::ST_LINK: begin
        link_reg_we = rd_cap;
      end
      splu_pkg::ST_BASE: begin
        gpr_we    = 1'b1;
        gpr_waddr = base_q;
        gpr_wdata = ea_q;
      end
      splu_pkg::ST_PAIR: begin
        // a faulted pair read writes nothing
        gpr_we     = rd_cap;
        gpr_waddr  = tgt_q;
        gpr_we2    = rd_cap;
        gpr_waddr2 = 5'(tgt_q + 5'h01);
      end
      default: begin
        // update form base write, one cycle after the pair data
        gpr_we    = upd_wb_q;
        gpr_waddr = base_q;
        gpr_wdata = ea_q;
      end
    endcase
  end

  // pair update form writes the address to the base after the data
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      upd_wb_q <= 1'b0;
    end else begin
      upd_wb_q <= (state_q == splu_pkg::ST_PAIR) && rd_cap && upd_q;
    end
  end

  // fault scratch: new stack pointer at start, faulting address on error
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fault_address_scratch_reg <= '0;
    end else if (mem_req && mem_ack && mem_err) begin
      fault_address_scratch_reg <= mem_addr;
    end else if (take && is_pop && !pop_bad) begin
      fault_address_scratch_reg <= base_val + cnt_ext;
    end
  end

  // exception and completion pulses
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      illegal_instr <= 1'b0;
      align_fault   <= 1'b0;
      data_fault    <= 1'b0;
      done          <= 1'b0;
    end else begin
      illegal_instr <= take && (is_pop ? pop_bad : pair_bad);
      align_fault   <= take && is_pop && !pop_bad &&
                       ((base_val[2:0] & splu_pkg::ALIGN_MASK) != splu_pkg::ZERO3);
      data_fault    <= (mem_req && mem_ack && mem_err) ||
                       (take && prior_store_fault);
      done          <= (state_q == splu_pkg::ST_BASE) ||
                       ((state_q == splu_pkg::ST_PAIR) && rd_cap && !upd_q) || upd_wb_q;
    end
  end

  // async events held while busy and released in the first idle cycle, which drops them when it carries the update base write
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
    end else if (async_event && busy) begin
      pend_q <= 1'b1;
    end else if (!busy) begin
      pend_q <= 1'b0;
    end
  end
  assign async_take = !busy && !upd_wb_q && (pend_q || async_event);

  // stack pointer write follows the link read by exactly one cycle
  base_last_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == splu_pkg::ST_LINK) && rd_cap |=> gpr_we && (gpr_waddr == base_q)
      && (gpr_wdata == ea_q))
    else $error("base write did not follow link read");
  no_sp_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == splu_pkg::ST_UPPER || state_q == splu_pkg::ST_LOWER) |->
      !(gpr_we && gpr_waddr == base_q) && !(gpr_we2 && gpr_waddr2 == base_q))
    else $error("stack pointer written from memory");
  async_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    busy |-> !async_take)
    else $error("async event taken mid instruction");
  fault_link_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    mem_err |-> !link_reg_we && !gpr_we && !gpr_we2)
    else $error("register written on faulted read");
  fault_addr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    mem_req && mem_ack && mem_err |=> fault_address_scratch_reg == $past(mem_addr))
    else $error("fault address not captured");
  sp_scratch_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    take && is_pop && !pop_bad |=> fault_address_scratch_reg == $past(base_val) + $past(cnt_ext)
      || data_fault)
    else $error("new stack pointer not in scratch");
  pop_illegal_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    take && is_pop && (doubleword_count_field[11:0] == '0) |=> illegal_instr
      && (state_q == splu_pkg::ST_IDLE))
    else $error("zero count pop not illegal");
  pop_align_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    take && is_pop && !pop_bad && (base_val[2:0] != splu_pkg::ZERO3) |=> align_fault && !busy)
    else $error("unaligned pop not faulted");
  link_addr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == splu_pkg::ST_LINK |-> mem_addr == ea_q + splu_pkg::OFS_LINK
      && mem_size == splu_pkg::ACC_WORD)
    else $error("link read at wrong address");
  rd_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    rd_cap |=> rd_hold == $past(mem_rdata))
    else $error("read data not held");
endmodule : splu_core

// ==== design/splu_pkg.sv ====
// package: shared constants for the stack pop and pair load unit
package splu_pkg;
  // instruction field positions (bit 31 is the msb of the word)
  localparam int unsigned OPC_MSB    = 31;
  localparam int unsigned OPC_LSB    = 26;
  localparam int unsigned TGT_MSB    = 25;
  localparam int unsigned TGT_LSB    = 21;
  localparam int unsigned BASE_MSB   = 20;
  localparam int unsigned BASE_LSB   = 16;
  localparam int unsigned IDX_MSB    = 15;
  localparam int unsigned IDX_LSB    = 11;
  localparam int unsigned DISP_MSB   = 15;
  localparam int unsigned DISP_LSB   = 0;
  localparam int unsigned CNT_MSB    = 15;
  localparam int unsigned CNT_LSB    = 3;
  localparam int unsigned XO_MSB     = 10;
  localparam int unsigned XO_LSB     = 1;
  localparam int unsigned SUB_MSB    = 2;
  localparam int unsigned SUB_LSB    = 0;
  // primary and extended opcodes
  localparam logic [5:0] OPC_POP     = 6'h3A;
  localparam logic [2:0] SUB_POP     = 3'h3;
  localparam logic [5:0] OPC_PAIR    = 6'h05;
  localparam logic [5:0] OPC_PAIR_U  = 6'h09;
  localparam logic [5:0] OPC_XFORM   = 6'h1F;
  localparam logic [9:0] XO_PAIR_X   = 10'h011;
  // register numbers and address offsets
  localparam logic [4:0]  REG_ZERO   = 5'h00;
  localparam logic [4:0]  REG_UP_HI  = 5'h1E;
  localparam logic [4:0]  REG_UP_LO  = 5'h1F;
  localparam logic [4:0]  REG_LO_HI  = 5'h1C;
  localparam logic [4:0]  REG_LO_LO  = 5'h1D;
  localparam logic [31:0] OFS_UPPER  = 32'hFFFF_FFF8;
  localparam logic [31:0] OFS_LOWER  = 32'hFFFF_FFF0;
  localparam logic [31:0] OFS_LINK   = 32'h0000_0004;
  localparam logic [12:0] CNT_ONE    = 13'h0001;
  localparam logic [12:0] CNT_TWO    = 13'h0002;
  localparam logic [2:0]  ALIGN_MASK = 3'h7;
  localparam logic [2:0]  ZERO3      = 3'h0;
  localparam logic [3:0]  ACC_WORD   = 4'h4;
  localparam logic [3:0]  ACC_DWORD  = 4'h8;
  // sequencer states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_UPPER = 6'b000010,
    ST_LOWER = 6'b000100,
    ST_LINK  = 6'b001000,
    ST_BASE  = 6'b010000,
    ST_PAIR  = 6'b100000
  } splu_state_e;
endpackage : splu_pkg

// ==== design/splu_rdata_reg.sv ====
// one-entry holding register for the memory read data
`timescale 1ns/1ps
module splu_rdata_reg #(
  parameter int unsigned WIDTH = 64
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // capture side
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] wdata,
  // held value
  output logic      [WIDTH-1:0] rdata
);
  // capture on load, clear on reset
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdata <= '0;
    end else if (load) begin
      rdata <= wdata;
    end
  end
endmodule : splu_rdata_reg

// ==== bench/splu_mem_model.sv ====
// memory subsystem model that answers the load requests of the unit
`timescale 1ns/1ps
module splu_mem_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // load port
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic             mem_ack,
  output logic             mem_err,
  output logic [63:0]      mem_rdata,
  // bench controls
  input  wire logic [1:0]  max_wait,
  input  wire logic        err_en,
  input  wire logic [31:0] err_addr
);
  logic [1:0] wait_q;  // cycles this request has waited
  logic [1:0] goal_q;  // wait chosen for this request
  // one answer per request after a random wait; data toggles while not acked
  always_ff @(posedge core_clk) begin
    if (reset_n == 1'b0) begin
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      mem_rdata <= 64'h0;
      wait_q    <= 2'h0;
      goal_q    <= 2'h0;
    end else if (mem_ack == 1'b1) begin
      // answer stands one cycle only, then data is no longer held
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_q    <= 2'h0;
      goal_q    <= 2'($urandom_range(int'(max_wait), 0));
    end else if (mem_req == 1'b1 && wait_q >= goal_q) begin
      // answer with data made from the address, fault only where commanded
      mem_ack   <= 1'b1;
      mem_err   <= err_en && (mem_addr == err_addr);
      mem_rdata <= {mem_addr ^ 32'h1111_1111, mem_addr ^ 32'h2222_2222};
    end else begin
      // stall, counting only while a request is up
      wait_q    <= wait_q + 2'(mem_req);
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : splu_mem_model

// ==== bench/tb_splu_core.sv ====
// self-checking bench for the stack pop and pair load sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_splu_core;
  logic        core_clk, reset_n, issue_valid, issue_ready, prior_store_fault;
  logic [31:0] instr, base_val, index_val, mem_addr, gpr_wdata, gpr_wdata2;
  logic        mem_req, mem_ack, mem_err, gpr_we, gpr_we2, link_reg_we;
  logic [3:0]  mem_size;
  logic [63:0] mem_rdata;
  logic [4:0]  gpr_waddr, gpr_waddr2;
  logic [31:0] link_reg_wdata, fault_address_scratch_reg, bv, err_addr;
  logic        done, illegal_instr, align_fault, data_fault, busy, async_event, async_take;
  logic [1:0]  max_wait;     // slowest memory answer
  logic        err_en;       // memory faults the read at err_addr
  int          fail_count, n_checks, w;
  logic [39:0] notes[$];     // expected events: kind, register or size, data
  // unit and memory partner
  splu_core splu_core_inst (.core_clk(core_clk), .reset_n(reset_n),
    .issue_valid(issue_valid), .issue_ready(issue_ready), .instr(instr),
    .base_val(base_val), .index_val(index_val), .prior_store_fault(prior_store_fault),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_size(mem_size), .mem_ack(mem_ack),
    .mem_err(mem_err), .mem_rdata(mem_rdata), .gpr_we(gpr_we), .gpr_waddr(gpr_waddr),
    .gpr_wdata(gpr_wdata), .gpr_we2(gpr_we2), .gpr_waddr2(gpr_waddr2),
    .gpr_wdata2(gpr_wdata2), .link_reg_we(link_reg_we), .link_reg_wdata(link_reg_wdata),
    .fault_address_scratch_reg(fault_address_scratch_reg), .done(done),
    .illegal_instr(illegal_instr), .align_fault(align_fault), .data_fault(data_fault),
    .busy(busy), .async_event(async_event), .async_take(async_take));
  splu_mem_model splu_mem_model_inst (.core_clk(core_clk), .reset_n(reset_n),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_err(mem_err),
    .mem_rdata(mem_rdata), .max_wait(max_wait), .err_en(err_en), .err_addr(err_addr));
  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // memory data pattern, same as the partner's
  function automatic logic [63:0] dat(input logic [31:0] a);
    return {a ^ 32'h1111_1111, a ^ 32'h2222_2222};
  endfunction : dat
  // short pop instruction word
  function automatic logic [31:0] popw(input logic [4:0] t, r, input logic [12:0] c);
    return {splu_pkg::OPC_POP, t, r, c, splu_pkg::SUB_POP};
  endfunction : popw
  task automatic note(input logic [2:0] k, input logic [4:0] r, input logic [31:0] d);
    notes.push_back({k, r, d});
  endtask : note
  // final report and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // offer one instruction and hold it until taken
  task automatic issue(input logic [31:0] ins, b, x);
    int i;
    @(negedge core_clk);
    issue_valid = 1'b1;
    instr = ins;
    base_val = b;
    index_val = x;
    for (i = 0; i < 50 && issue_ready !== 1'b1; i++) @(negedge core_clk);
    if (i == 50) begin
      fail_count++;
      $display("CHECK FAILED issue_ready exp 1 got 0");
      close_out();
    end
    @(posedge core_clk);
    @(negedge core_clk);
    issue_valid = 1'b0;
  endtask : issue
  // wait until every expected event was seen
  task automatic drain(input string nm);
    int i;
    for (i = 0; i < 300 && notes.size() > 0; i++) @(negedge core_clk);
    if (i == 300) begin
      fail_count++;
      $display("CHECK FAILED %s exp events got none", nm);
      close_out();
    end
    repeat (3) @(negedge core_clk);
    $display("test %s done", nm);
  endtask : drain
  // one doubleword read and its pair writes, the base register half skipped
  task automatic step(input logic [4:0] t, input logic [31:0] a, input logic [4:0] skip,
                      inout logic dead);
    logic [63:0] v;
    v = dat(a);
    note(3'd7, 5'h08, a);
    if (err_en && a == err_addr) begin
      note(3'd6, 5'h00, a);
      dead = 1'b1;
    end else begin
      if (t != skip) note(3'd1, t, v[63:32]);
      if (t + 5'h01 != skip) note(3'd2, t + 5'h01, v[31:0]);
    end
  endtask : step
  // legal short pop with all its expected events
  task automatic pop(input logic [4:0] r, input logic [12:0] c, input logic [31:0] b);
    logic [31:0] ea;
    logic [63:0] v;
    logic        dead;
    ea = b + {{16{c[12]}}, c, 3'h0};
    dead = 1'b0;
    if (c > 13'h0001) step(5'h1E, ea - 32'h8, r, dead);
    if (c > 13'h0002 && !dead) step(5'h1C, ea - 32'h10, r, dead);
    if (!dead) begin
      v = dat(ea + 32'h4);
      note(3'd7, 5'h04, ea + 32'h4);
      if (err_en && ea + 32'h4 == err_addr) begin
        note(3'd6, 5'h00, ea + 32'h4);
        dead = 1'b1;
      end
    end
    if (!dead) begin
      note(3'd3, 5'h00, v[31:0]);
      note(3'd1, r, ea);
      note(3'd0, 5'h00, ea);
    end
    issue(popw(r, r, c), b, 32'h0);
  endtask : pop
  // pair load of any of three forms; k 0 displacement, 1 update, 2 indexed
  task automatic pair(input int k, input logic [4:0] t, ra, input logic [15:0] d,
                      input logic [31:0] b, x);
    logic [31:0] a;
    logic        dead;
    dead = 1'b0;
    a = ((ra == 5'h00 && k != 1) ? 32'h0 : b) + ((k == 2) ? x : {{16{d[15]}}, d});
    if (t[0] || (k == 1 && (ra == 5'h00 || ra == t || ra == t + 5'h01)))
      note(3'd4, 5'h00, 32'h0);
    else begin
      step(t, a, 5'h00, dead);
      if (k == 1) note(3'd1, ra, a);
      note(3'd0, 5'h1F, 32'h0);
    end
    if (k == 2) issue({splu_pkg::OPC_XFORM, t, ra, d[15:11], splu_pkg::XO_PAIR_X, 1'b0}, b, x);
    else issue({(k == 1) ? splu_pkg::OPC_PAIR_U : splu_pkg::OPC_PAIR, t, ra, d}, b, x);
  endtask : pair
  // refused instruction expecting one exception pulse
  task automatic bad(input logic [31:0] ins, b, input logic [2:0] k, input logic [4:0] r);
    note(k, r, 32'h0);
    issue(ins, b, 32'h0);
  endtask : bad
  // observed event against the oldest note
  task automatic see(input logic [39:0] o);
    logic [39:0] e;
    if (notes.size() == 0) begin
      n_checks++;
      fail_count++;
      $display("CHECK FAILED event exp none got %h", o);
    end else begin
      e = notes.pop_front();
      if ((e[39:37] == 3'd0 || e[39:37] == 3'd6) && e[36:32] == 5'h1F) o[36:0] = e[36:0];
      `CHK("event", e, o)
    end
  endtask : see
  // watcher of every result the unit produces
  always @(posedge core_clk) begin
    if (reset_n === 1'b1) begin
      if (mem_req === 1'b1 && mem_ack === 1'b1) see({3'd7, 1'b0, mem_size, mem_addr});
      if (gpr_we === 1'b1) see({3'd1, gpr_waddr, gpr_wdata});
      if (gpr_we2 === 1'b1) see({3'd2, gpr_waddr2, gpr_wdata2});
      if (link_reg_we === 1'b1) see({3'd3, 5'h00, link_reg_wdata});
      if (done === 1'b1) see({3'd0, 5'h00, fault_address_scratch_reg});
      if (illegal_instr === 1'b1) see({3'd4, 5'h00, 32'h0});
      if (align_fault === 1'b1) see({3'd5, 5'h00, 32'h0});
      if (data_fault === 1'b1) see({3'd6, 5'h00, fault_address_scratch_reg});
      if (async_take === 1'b1 && busy === 1'b1) `CHK("async_take", 1'b0, 1'b1)
    end
  end
  // main sequence
  initial begin
    {issue_valid, prior_store_fault, async_event, err_en} = 4'h0;
    {instr, base_val, index_val, err_addr} = 128'h0;
    max_wait = 2'h0;
    fail_count = 0;
    n_checks = 0;
    reset_n = 1'b0;
    void'($urandom(32'h78e1fbff));
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    for (w = 0; w < 4; w += 3) begin
      max_wait = 2'(w);
      bv = ($urandom() & 32'h00FF_FFF8) | 32'h0001_0000;
      pop(5'h01, 13'h0001, bv);
      pop(5'h05, 13'h0002, bv);
      pop(5'h1F, 13'h0003, bv);
      pop(5'h1E, 13'h0003, bv);
      pop(5'h1D, 13'h0004, bv);
      pop(5'h1C, 13'h0FFF, bv);
      drain("pop counts");
    end
    bad(popw(5'h00, 5'h00, 13'h0003), bv, 3'd4, 5'h00);
    bad(popw(5'h02, 5'h01, 13'h0003), bv, 3'd4, 5'h00);
    bad(popw(5'h01, 5'h01, 13'h1001), bv, 3'd4, 5'h00);
    bad(popw(5'h01, 5'h01, 13'h0000), bv, 3'd4, 5'h00);
    bad(popw(5'h01, 5'h01, 13'h1000), bv, 3'd4, 5'h00);
    bad(popw(5'h01, 5'h01, 13'h0003), bv | 32'h4, 3'd5, 5'h00);
    drain("pop refusals");
    err_en = 1'b1;
    err_addr = bv + 32'h8;
    pop(5'h01, 13'h0003, bv);
    drain("fault on lower pair");
    err_addr = bv + 32'h14;
    pop(5'h03, 13'h0002, bv);
    drain("fault on link word");
    err_en = 1'b0;
    prior_store_fault = 1'b1;
    bad(popw(5'h01, 5'h01, 13'h0003), bv, 3'd6, 5'h1F);
    drain("earlier store fault");
    prior_store_fault = 1'b0;
    async_event = 1'b1;
    pop(5'h01, 13'h0003, bv);
    drain("event held");
    `CHK("async_take", 1'b1, async_take)
    async_event = 1'b0;
    for (w = 0; w < 3; w++) begin
      bv = ($urandom() & 32'h00FF_FFF8) | 32'h0001_0000;
      pair(w, 5'h1E, 5'h03, 16'hFFF0, bv, bv >> 4 & 32'h0000_FFF8);
      pair(w, 5'h04, 5'h00, 16'h0028, bv, 32'h0000_0100);
      pair(w, 5'h07, 5'h03, 16'h0008, bv, 32'h0);
      pair(w, 5'h1E, 5'h1F, 16'h0010, bv, 32'h0000_0010);
      pair(w, 5'h06, 5'h06, 16'h0018, bv, 32'h0000_0020);
      drain("pair loads");
    end
    close_out();
  end
endmodule : tb_splu_core
